// ==== pkg/tfe_cfg.svh ====
// Constants for the transmit FIFO event control block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TFE_CFG_SVH
`define TFE_CFG_SVH

`define TFE_ADDR_W        12
`define TFE_CTRL_ADDR     12'h000
`define TFE_STAT_ADDR     12'h004

`define TFE_CTRL_RESET    32'h0000_0000
`define TFE_CTRL_WMASK    32'hD73F_FF00
`define TFE_STAT_CLRMASK  32'h0000_0300

`define TFE_LIMIT_MSB     13
`define TFE_LIMIT_LSB     8
`define TFE_TRIG_MODE_BIT 14
`define TFE_TRIG_EN_BIT   15
`define TFE_STD_RT_MSB    18
`define TFE_STD_RT_LSB    16
`define TFE_ALT_RT_MSB    21
`define TFE_ALT_RT_LSB    19
`define TFE_SIZE_MSB      26
`define TFE_SIZE_LSB      24
`define TFE_LOF_BIT       28
`define TFE_STD_IEN_BIT   30
`define TFE_ERR_IEN_BIT   31

`define TFE_ST_LVL_MSB    6
`define TFE_ST_LVL_LSB    0
`define TFE_ST_STD_BIT    8
`define TFE_ST_ERR_BIT    9
`define TFE_ST_FULL_BIT   10
`define TFE_ST_EMPTY_BIT  11

`define TFE_SR_NUM        6
`define TFE_LIMIT_W       6
`define TFE_LVL_W         7
`define TFE_SIZE_OFF      3'h0
`define TFE_LVL_ZERO      7'h00
`define TFE_LVL_ONE       7'h01

`endif

// ==== pkg/tfe_pkg.sv ====
// Types shared by the transmit FIFO event control block.
// Assumes tfe_cfg.svh is on the include path.
`include "tfe_cfg.svh"

package tfe_pkg;
   typedef logic [`TFE_SR_NUM-1:0]  tfe_sr_vec_type;
   typedef logic [`TFE_LVL_W-1:0]   tfe_lvl_type;
   typedef logic [`TFE_LIMIT_W-1:0] tfe_limit_type;
   typedef logic [2:0]              tfe_route_type;
   typedef logic [2:0]              tfe_size_type;
   typedef logic [`TFE_ADDR_W-1:0]  tfe_addr_type;
endpackage

// ==== verilog/tfe_level.sv ====
// Filling level counter of the transmit FIFO.
// Assumes the caller only raises push or pop when the move is legal.
`timescale 1ns/100ps
`include "tfe_cfg.svh"

module tfe_level #(
   parameter int LVL_W = `TFE_LVL_W
) (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               clr,
   input  wire logic               push,
   input  wire logic               pop,
   output tfe_pkg::tfe_lvl_type    level
);
   import tfe_pkg::*;

   tfe_lvl_type level_r;
   tfe_lvl_type level_nxt;

   if (LVL_W != `TFE_LVL_W) begin : g_chk
      $error("tfe_level: LVL_W must match the package level width");
   end

   always_comb begin
      level_nxt = level_r;
      if (clr) begin
         level_nxt = `TFE_LVL_ZERO;
      end else if (push && !pop) begin
         level_nxt = tfe_lvl_type'(level_r + `TFE_LVL_ONE);
      end else if (pop && !push) begin
         level_nxt = tfe_lvl_type'(level_r - `TFE_LVL_ONE);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         level_r <= `TFE_LVL_ZERO;
      end else begin
         level_r <= level_nxt;
      end
   end

   assign level = level_r;
endmodule

// ==== verilog/tfe_top.sv ====
// Transmit FIFO control: depth, limit event, error event and routing
// of both onto six service request lines, with an APB register slave.
// Assumes writer and drain strobes come from logic on ref_clk.
//
// Function
// - Standard event goes to service request line 0..5 by its route code.
// - Error event goes to line 0..5 by its own route code.
// - Depth code zero disables the FIFO and refuses all data requests.
// - Depth code n from 1 to 6 gives two to the n entries.
// - Direction 0: event when level equals limit and a drain lowers it.
// - Direction 1: event when level equals limit and a write raises it.
// - Standard event requests service only while its enable is set.
// - Write to full buffer is an error event; interrupt only if enabled.
// - Reserved control bits read as zero; software writes zero there.
// - The level is compared against a six bit limit field.
// - Control writes are ignored unless the transmit buffer is present.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "tfe_cfg.svh"

module tfe_top #(
   parameter int SR_NUM  = `TFE_SR_NUM,
   parameter int LIMIT_W = `TFE_LIMIT_W,
   parameter int LVL_W   = `TFE_LVL_W
) (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  tfe_pkg::tfe_addr_type   paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               tx_buffer_present,
   input  wire logic               wr_req,
   input  wire logic               tx_pop,
   output logic                    wr_accept,
   output logic                    wr_refuse,
   output logic                    pop_accept,
   output tfe_pkg::tfe_lvl_type    tx_fill_level,
   output tfe_pkg::tfe_sr_vec_type service_request_line
);
   import tfe_pkg::*;

   if (SR_NUM != `TFE_SR_NUM || LIMIT_W != `TFE_LIMIT_W ||
       LVL_W != `TFE_LVL_W) begin : g_chk
      $error("tfe_top: widths must match the package types");
   end

   // Entry count of a depth code; zero means the FIFO is off
   function automatic tfe_lvl_type depth_of(input tfe_size_type code);
      tfe_lvl_type d;
      d = `TFE_LVL_ZERO;
      if (code != `TFE_SIZE_OFF) begin
         d = tfe_lvl_type'(`TFE_LVL_ONE << code);
      end
      return d;
   endfunction

   // One-hot line for a route code; reserved codes give none
   function automatic tfe_sr_vec_type route_of(input tfe_route_type code);
      tfe_sr_vec_type v;
      v = '0;
      if (32'(code) < SR_NUM) begin
         v[code] = 1'b1;
      end
      return v;
   endfunction

   // Register bus state
   logic [31:0]    ctrl_r;
   logic [31:0]    ctrl_nxt;
   logic [31:0]    prdata_r;
   logic [31:0]    prdata_nxt;
   logic           pready_r;
   logic           pready_nxt;
   logic           pslverr_r;
   logic           pslverr_nxt;
   logic           std_flag_r;
   logic           std_flag_nxt;
   logic           err_flag_r;
   logic           err_flag_nxt;

   // Datapath event state
   tfe_sr_vec_type sr_r;
   tfe_sr_vec_type sr_nxt;
   logic           wr_acc_r;
   logic           wr_acc_nxt;
   logic           wr_ref_r;
   logic           wr_ref_nxt;
   logic           pop_acc_r;
   logic           pop_acc_nxt;

   // Decoded control fields
   tfe_size_type   size_code;
   tfe_limit_type  limit;
   tfe_route_type  std_route;
   tfe_route_type  alt_route;
   logic           limit_crossing_direction;
   logic           std_ien;
   logic           err_ien;

   tfe_lvl_type    level;
   tfe_lvl_type    depth;
   logic           fifo_on;
   logic           full;
   logic           empty;
   logic           push_ok;
   logic           pop_ok;
   logic           std_evt;
   logic           err_evt;
   logic           at_limit;
   logic           lvl_clr;
   logic           setup;
   logic           access;
   logic           ctrl_wr;
   logic           stat_wr;
   logic [31:0]    status;

   assign size_code = ctrl_r[`TFE_SIZE_MSB:`TFE_SIZE_LSB];
   assign limit     = ctrl_r[`TFE_LIMIT_MSB:`TFE_LIMIT_LSB];
   assign std_route = ctrl_r[`TFE_STD_RT_MSB:`TFE_STD_RT_LSB];
   assign alt_route = ctrl_r[`TFE_ALT_RT_MSB:`TFE_ALT_RT_LSB];
   assign limit_crossing_direction       = ctrl_r[`TFE_LOF_BIT];
   assign std_ien   = ctrl_r[`TFE_STD_IEN_BIT];
   assign err_ien   = ctrl_r[`TFE_ERR_IEN_BIT];

   assign depth   = depth_of(size_code);
   assign fifo_on = (size_code != `TFE_SIZE_OFF);
   assign full    = fifo_on && (level == depth);
   assign empty   = (level == `TFE_LVL_ZERO);

   // A disabled FIFO takes neither writes nor drains
   assign push_ok  = wr_req && fifo_on && !full;
   assign pop_ok   = tx_pop && fifo_on && !empty;
   assign err_evt  = wr_req && full;
   assign at_limit = (level == tfe_lvl_type'(limit));

   // A write and a drain in the same cycle leave the level unchanged,
   // so neither crosses the limit
   always_comb begin
      if (limit_crossing_direction) begin
         std_evt = push_ok && !pop_ok && at_limit;
      end else begin
         std_evt = pop_ok && !push_ok && at_limit;
      end
   end

   assign setup   = psel && !penable;
   assign access  = psel && penable && pready_r;
   assign ctrl_wr = access && pwrite && (paddr == `TFE_CTRL_ADDR);
   assign stat_wr = access && pwrite && (paddr == `TFE_STAT_ADDR);

   // New depth invalidates the old contents
   assign lvl_clr = ctrl_wr && tx_buffer_present &&
                    (pwdata[`TFE_SIZE_MSB:`TFE_SIZE_LSB] != size_code);

   always_comb begin
      status = 32'h0000_0000;
      status[`TFE_ST_LVL_MSB:`TFE_ST_LVL_LSB] = level;
      status[`TFE_ST_STD_BIT]   = std_flag_r;
      status[`TFE_ST_ERR_BIT]   = err_flag_r;
      status[`TFE_ST_FULL_BIT]  = full;
      status[`TFE_ST_EMPTY_BIT] = empty;
   end

   always_comb begin
      ctrl_nxt    = ctrl_r;
      prdata_nxt  = 32'h0000_0000;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      if (setup) begin
         pready_nxt = 1'b1;
         case (paddr)
            `TFE_CTRL_ADDR: begin
               prdata_nxt = ctrl_r & `TFE_CTRL_WMASK;
            end
            `TFE_STAT_ADDR: begin
               prdata_nxt = status;
            end
            default: begin
               pslverr_nxt = 1'b1;
            end
         endcase
      end else if (psel && penable && !pready_r) begin
         prdata_nxt  = prdata_r;
         pslverr_nxt = pslverr_r;
      end
      if (ctrl_wr && tx_buffer_present) begin
         ctrl_nxt = pwdata & `TFE_CTRL_WMASK;
      end
   end

   // Hardware set beats a software clear in the same cycle
   always_comb begin
      std_flag_nxt = std_flag_r;
      err_flag_nxt = err_flag_r;
      if (stat_wr && pwdata[`TFE_ST_STD_BIT]) begin
         std_flag_nxt = 1'b0;
      end
      if (stat_wr && pwdata[`TFE_ST_ERR_BIT]) begin
         err_flag_nxt = 1'b0;
      end
      if (std_evt) begin
         std_flag_nxt = 1'b1;
      end
      if (err_evt) begin
         err_flag_nxt = 1'b1;
      end
   end

   always_comb begin
      sr_nxt = '0;
      if (std_evt && std_ien) begin
         sr_nxt = sr_nxt | route_of(std_route);
      end
      if (err_evt && err_ien) begin
         sr_nxt = sr_nxt | route_of(alt_route);
      end
      wr_acc_nxt  = push_ok;
      wr_ref_nxt  = wr_req && !push_ok;
      pop_acc_nxt = pop_ok;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_r     <= `TFE_CTRL_RESET;
         prdata_r   <= 32'h0000_0000;
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
         std_flag_r <= 1'b0;
         err_flag_r <= 1'b0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         prdata_r   <= prdata_nxt;
         pready_r   <= pready_nxt;
         pslverr_r  <= pslverr_nxt;
         std_flag_r <= std_flag_nxt;
         err_flag_r <= err_flag_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sr_r      <= '0;
         wr_acc_r  <= 1'b0;
         wr_ref_r  <= 1'b0;
         pop_acc_r <= 1'b0;
      end else begin
         sr_r      <= sr_nxt;
         wr_acc_r  <= wr_acc_nxt;
         wr_ref_r  <= wr_ref_nxt;
         pop_acc_r <= pop_acc_nxt;
      end
   end

   tfe_level #(
      .LVL_W (LVL_W)
   ) u_level (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clr     (lvl_clr),
      .push    (push_ok),
      .pop     (pop_ok),
      .level   (level)
   );

   assign prdata               = prdata_r;
   assign pready               = pready_r;
   assign pslverr              = pslverr_r;
   assign wr_accept            = wr_acc_r;
   assign wr_refuse            = wr_ref_r;
   assign pop_accept           = pop_acc_r;
   assign tx_fill_level        = level;
   assign service_request_line = sr_r;
endmodule

// ==== testbench/tfe_top_properties.sv ====
// Concurrent checks on the transmit FIFO event control ports.
// Assumes binding into tfe_top; sees only its ports.
`timescale 1ns/100ps

module tfe_top_properties (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic              wr_req,
   input wire logic              tx_pop,
   input wire logic              wr_accept,
   input wire logic              wr_refuse,
   input wire logic              pop_accept,
   input tfe_pkg::tfe_lvl_type    tx_fill_level,
   input tfe_pkg::tfe_sr_vec_type service_request_line
);
   import tfe_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_accept_cause: assert property (wr_accept |->
      $past(wr_req) && !wr_refuse)
      else $error("accept without a write strobe");
   a_level_rise: assert property (wr_accept && !pop_accept |->
      tx_fill_level == $past(tx_fill_level) + 7'h01)
      else $error("level did not rise by one");
   a_level_fall: assert property (pop_accept && !wr_accept |->
      tx_fill_level == $past(tx_fill_level) - 7'h01)
      else $error("level did not fall by one");
   a_pop_empty: assert property (tx_pop &&
      tx_fill_level == 7'h00 |=> !pop_accept)
      else $error("pop accepted while empty");
   a_line_cause: assert property (service_request_line != 6'h00 |->
      $past(wr_req) || $past(tx_pop))
      else $error("service request without a strobe");
   a_line_count: assert property (
      $countones(service_request_line) <= 2)
      else $error("more lines than events");
   a_pop_line: assert property (service_request_line != 6'h00 &&
      !wr_accept && !wr_refuse |-> pop_accept)
      else $error("drain event without accepted pop");
   a_refuse_hold: assert property (wr_refuse && !pop_accept |->
      $stable(tx_fill_level))
      else $error("refused write moved the level");
   a_line_source: assert property (service_request_line != 6'h00 |->
      wr_accept || wr_refuse || pop_accept)
      else $error("service request without a strobe result");
endmodule

bind tfe_top tfe_top_properties tfe_top_properties_i (.ref_clk, .rst,
   .wr_req, .tx_pop, .wr_accept, .wr_refuse, .pop_accept, .tx_fill_level,
   .service_request_line);

// ==== testbench/tfe_far_end.sv ====
// Far side model: software writer and transmit shift logic strobes.
// Assumes go requests from the bench on ref_clk; emits one-cycle pulses.
`timescale 1ns/100ps

module tfe_far_end (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic wr_go,
   input  wire logic pop_go,
   output logic      wr_req,
   output logic      tx_pop
);
   logic wr_nxt;
   logic pop_nxt;

   always_comb begin
      wr_nxt  = wr_go & ~rst;
      pop_nxt = pop_go & ~rst;
   end

   always_ff @(posedge ref_clk) begin
      wr_req <= wr_nxt;
      tx_pop <= pop_nxt;
   end
endmodule

// ==== testbench/tfe_top_bench.sv ====
// Self-checking bench for tfe_top with APB master and strobe model.
// Assumes the design answers APB within the bench's wait bound.
`timescale 1ns/100ps

module tfe_top_bench;
   import tfe_pkg::*;
   logic           ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   tfe_addr_type   paddr = 12'h000;
   logic [31:0]    pwdata = 32'h0, prdata;
   logic           pready, pslverr, wr_req, tx_pop, wr_accept, wr_refuse;
   logic           pop_accept, present = 0, wr_go = 0, pop_go = 0;
   tfe_lvl_type    lvl;
   tfe_sr_vec_type srl;
   logic [32:0]    rd_q[$];
   logic [8:0]     ev_q[$];
   logic [32:0]    rx;
   logic [8:0]     ex;
   int             fails = 0, checks = 0, dep, lim;

   tfe_top tfe_top_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tx_buffer_present(present),
      .wr_req, .tx_pop, .wr_accept, .wr_refuse, .pop_accept,
      .tx_fill_level(lvl), .service_request_line(srl));
   tfe_far_end tfe_far_end_i (.ref_clk, .rst, .wr_go, .pop_go, .wr_req,
      .tx_pop);

   always #2 ref_clk = ~ref_clk;

   function automatic logic [5:0] line(input logic [2:0] c);
      line = (c < 3'h6) ? 6'h01 << c : 6'h00;
   endfunction

   function automatic logic [31:0] cfg(input logic e, s, d,
      input logic [2:0] sz, alt, std, input logic [5:0] l);
      cfg = {e, s, 1'b0, d, 1'b0, sz, 2'h0, alt, std, 2'h0, l, 8'h00};
   endfunction

   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic apb(input logic w, input tfe_addr_type a,
      input logic [32:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d[31:0];
      if (!w) rd_q.push_back(d);
      @(posedge ref_clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1) begin
         fails++;
         final_report();
      end
   endtask

   task automatic strobe(input logic w, input logic [8:0] e);
      @(posedge ref_clk);
      wr_go <= w;
      pop_go <= !w;
      if (e !== 9'h000) ev_q.push_back(e);
      @(posedge ref_clk);
      wr_go <= 0;
      pop_go <= 0;
   endtask

   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         rx = rd_q.pop_front();
         checks++;
         if ({pslverr, prdata} !== rx) begin
            fails++;
            $display("FAIL prdata exp %h got %h", rx, {pslverr, prdata});
         end
      end
      if ({wr_accept, wr_refuse, pop_accept, srl} !== 9'h000) begin
         ex = ev_q.pop_front();
         checks++;
         if ({wr_accept, wr_refuse, pop_accept, srl} !== ex) begin
            fails++;
            $display("FAIL events exp %h got %h", ex,
               {wr_accept, wr_refuse, pop_accept, srl});
         end
      end
   end

   initial begin
      void'($urandom(32'h44C3));
      repeat (5) @(posedge ref_clk);
      rst <= 0;
      apb(0, 12'h004, 33'h0_0000_0800);
      apb(0, 12'h008, 33'h1_0000_0000);
      strobe(1, 9'h080);
      strobe(0, 9'h000);
      apb(1, 12'h000, 33'h0_FFFF_FFFF);
      apb(0, 12'h000, 33'h0_0000_0000);
      present <= 1;
      apb(1, 12'h000, 33'h0_FFFF_FFFF);
      apb(0, 12'h000, 33'h0_D73F_FF00);
      for (int r = 0; r < 8; r++) begin
         apb(1, 12'h000, {1'b0, cfg(1, 1, 1, 3'h1, 3'(7 - r), 3'(r), 6'h00)});
         strobe(1, {3'h4, line(3'(r))});
         strobe(1, 9'h100);
         strobe(1, {3'h2, line(3'(7 - r))});
         strobe(0, 9'h040);
         strobe(0, 9'h040);
      end
      for (int s = 1; s < 7; s++) begin
         dep = 1 << s;
         lim = $urandom % (dep - 1) + 1;
         apb(1, 12'h000, {1'b0, cfg(0, s[0], 0, 3'(s), 3'h0, 3'h5, 6'(lim))});
         apb(1, 12'h004, 33'h0_0000_0300);
         repeat (dep) strobe(1, 9'h100);
         strobe(1, 9'h080);
         apb(0, 12'h004, {1'b0, 32'(dep) | 32'h0000_0600});
         for (int i = dep; i > 0; i--)
            strobe(0, {3'h1,
               (i == lim && s[0]) ? 6'h20 : 6'h00});
      end
      repeat (4) @(posedge ref_clk);
      checks++;
      if (rd_q.size() + ev_q.size() != 0) begin
         fails++;
         $display("FAIL queues exp 0 got %0d", rd_q.size() + ev_q.size());
      end
      final_report();
   end
endmodule
